// ===== core/acc_ctrl.sv
// Analog comparator control: input routing, power, sync, flag, capture.
// Assumes an AXI4-Lite master on aclk and an analog core outside.
//
// How it works
// (R01) Mux enabled and converter off: converter mux drives negative input.
// (R02) Mux enable clear: negative pin drives negative input.
// (R03) Channel code 000..111 picks converter pin 0..7 when muxed.
// (R04) Power-off bit set removes comparator power; writable anytime.
// (R05) Software clears irq enable before changing power-off bit.
// (R06) Bandgap bit picks internal reference, else positive pin.
// (R07) Output high when positive input exceeds negative input.
// (R08) Output status bit is synchronised, lagging one to two clocks.
// (R09) Flag set by hardware on the event the mode bits choose.
// (R10) Modes: 00 toggle, 01 reserved, 10 falling, 11 rising.
// (R11) Edges come from current and previous synchronised samples.
// (R12) Request while flag, enable and global enable all set.
// (R13) Flag clears when processor vectors to the handler.
// (R14) Writing one to flag clears it; zero leaves it.
// (R15) Capture bit routes output to timer capture front end.
// (R16) Software also enables timer capture interrupt in timer mask.
// (R17) Software clears irq enable before changing mode bits.
// (R18) Pin input-off bit disables buffer; port bit reads zero.
// (R19) Software sets input-off bits for analog-only pins.
// (R20) Upper six input-disable bits read as zero.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module acc_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog comparator core
  input  wire logic        cmp_raw_out,
  output logic             cmp_power_off,
  output logic             cmp_bandgap_select,
  output logic [3:0]       cmp_neg_select,
  // Pin input buffers
  input  wire logic        neg_pin_digital,
  input  wire logic        pos_pin_digital,
  output logic             neg_pin_input_off,
  output logic             pos_pin_input_off,
  output logic             neg_pin_port_bit,
  output logic             pos_pin_port_bit,
  // Processor interrupt hand-shake
  input  wire logic        cpu_vector_ack,
  output logic             cmp_irq_req,
  // Timer capture front end
  output logic             cmp_capture_route,
  output logic             timer_capture_in
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic       power_off_r;
  logic       bandgap_r;
  logic       irq_flag_r;
  logic       irq_enable_r;
  logic       capture_r;
  logic [1:0] mode_r;
  logic [2:0] trig_src_r;
  logic       mux_enable_r;
  logic [1:0] pin_off_r;
  logic       conv_enable_r;
  logic [2:0] chan_r;
  logic       global_ie_r;
  logic       out_sync;
  logic       out_prev_r;
  logic       event_hit;

  // Bus handshake state
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       do_write;
  logic       flag_clr;

  function automatic logic acc_known(input logic [7:0] addr);
    acc_known = (addr == ACC_OFF_CTRL_STAT) || (addr == ACC_OFF_CONV_B) ||
                (addr == ACC_OFF_PIN_DIS)   || (addr == ACC_OFF_HOOKS);
  endfunction : acc_known

  // ----------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[9:2];            // Word index
      end
      else if (do_write)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (do_write)
        w_held_r <= 1'b0;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ACC_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= acc_known(aw_addr_r) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Power-off may be written at any time; no interlock here  // see (R04)
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power_off_r  <= ACC_RST_CTRL[ACC_B_POWER_OFF];
      bandgap_r    <= ACC_RST_CTRL[ACC_B_BANDGAP];
      irq_enable_r <= ACC_RST_CTRL[ACC_B_IRQ_ENABLE];
      capture_r    <= ACC_RST_CTRL[ACC_B_CAPTURE];
      mode_r       <= ACC_RST_CTRL[ACC_B_MODE_HI:ACC_B_MODE_LO];
    end
    else if (do_write && w_strb_r[0] && aw_addr_r == ACC_OFF_CTRL_STAT)
    begin
      power_off_r  <= w_data_r[ACC_B_POWER_OFF];   // see (R04)
      bandgap_r    <= w_data_r[ACC_B_BANDGAP];
      irq_enable_r <= w_data_r[ACC_B_IRQ_ENABLE];
      capture_r    <= w_data_r[ACC_B_CAPTURE];
      mode_r       <= w_data_r[ACC_B_MODE_HI:ACC_B_MODE_LO];
    end
  end

  // Converter control B and pin disables; reserved bits never stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mux_enable_r <= ACC_RST_CONVB[ACC_B_MUX_ENABLE];
      trig_src_r   <= ACC_RST_CONVB[2:0];
      pin_off_r    <= ACC_RST_PIN[1:0];
    end
    else if (do_write && w_strb_r[0])
    begin
      if (aw_addr_r == ACC_OFF_CONV_B)
      begin
        mux_enable_r <= w_data_r[ACC_B_MUX_ENABLE];
        trig_src_r   <= w_data_r[2:0];
      end
      if (aw_addr_r == ACC_OFF_PIN_DIS)
        pin_off_r <= w_data_r[1:0];                // see (R20)
    end
  end

  // Hooks standing in for converter enable, channel, global enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conv_enable_r <= 1'b0;
      chan_r        <= ACC_RST_CHAN;
      global_ie_r   <= 1'b0;
    end
    else if (do_write && aw_addr_r == ACC_OFF_HOOKS)
    begin
      if (w_strb_r[0])
      begin
        conv_enable_r <= w_data_r[ACC_B_CONV_EN];
        chan_r        <= w_data_r[ACC_B_CHAN_LO +: 3];
      end
      if (w_strb_r[1])
        global_ie_r <= w_data_r[ACC_B_GLOBAL_IE];
    end
  end

  // ----------------------------------------------------------------------
  // Analog routing
  // ----------------------------------------------------------------------
  // Converter pin only when muxed and converter off; else negative pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmp_neg_select <= ACC_NEG_PIN;
    else if (mux_enable_r && !conv_enable_r)       // see (R01)
      cmp_neg_select <= {1'b0, chan_r};            // see (R03)
    else
      cmp_neg_select <= ACC_NEG_PIN;               // see (R02)
  end

  assign cmp_power_off      = power_off_r;         // see (R04)
  assign cmp_bandgap_select = bandgap_r;           // see (R06)
  assign cmp_capture_route  = capture_r;
  assign neg_pin_input_off  = pin_off_r[ACC_B_NEG_OFF];
  assign pos_pin_input_off  = pin_off_r[ACC_B_POS_OFF];

  // Port bits read zero while the digital buffer is off
  assign neg_pin_port_bit = neg_pin_digital && !neg_pin_input_off; // see (R18)
  assign pos_pin_port_bit = pos_pin_digital && !pos_pin_input_off; // see (R18)

  // ----------------------------------------------------------------------
  // Output synchronisation and events
  // ----------------------------------------------------------------------
  // Raw output is high when positive exceeds negative, from the core
  acc_sync u_sync (                                // see (R07)
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (cmp_raw_out),
    .q       (out_sync)                            // see (R08)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_prev_r <= 1'b0;
    else
      out_prev_r <= out_sync;                      // see (R11)
  end

  // Reserved mode raises nothing
  always_comb
  begin
    case (acc_mode_t'(mode_r))                     // see (R10)
      ACC_MODE_TOGGLE: event_hit = out_sync ^ out_prev_r;
      ACC_MODE_FALL:   event_hit = !out_sync && out_prev_r;
      ACC_MODE_RISE:   event_hit = out_sync && !out_prev_r;
      default:         event_hit = 1'b0;
    endcase
  end

  assign flag_clr = cpu_vector_ack ||              // see (R13)
                    (do_write && w_strb_r[0] &&
                     aw_addr_r == ACC_OFF_CTRL_STAT &&
                     w_data_r[ACC_B_IRQ_FLAG]);    // see (R14)

  // A new event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_flag_r <= ACC_RST_CTRL[ACC_B_IRQ_FLAG];
    else if (event_hit)
      irq_flag_r <= 1'b1;                          // see (R09)
    else if (flag_clr)
      irq_flag_r <= 1'b0;
  end

  // Request is a combinational level of three conditions
  assign cmp_irq_req = irq_flag_r && irq_enable_r && global_ie_r; // see (R12)

  // Synchronised output goes to capture only when routed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_capture_in <= 1'b0;
    else
      timer_capture_in <= capture_r && out_sync;   // see (R15)
  end

  // ----------------------------------------------------------------------
  // Read channel: one cycle to rvalid, unmapped answers SLVERR
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ACC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= ACC_RESP_OKAY;
      case (s_axi_araddr[9:2])
        ACC_OFF_CTRL_STAT:
          s_axi_rdata <= {24'h0, power_off_r, bandgap_r, out_sync,
                          irq_flag_r, irq_enable_r, capture_r, mode_r};
        ACC_OFF_CONV_B:
          s_axi_rdata <= {24'h0, 1'b0, mux_enable_r, 3'h0, trig_src_r};
        ACC_OFF_PIN_DIS:
          s_axi_rdata <= {24'h0, 6'h00, pin_off_r}; // see (R20)
        ACC_OFF_HOOKS:
          s_axi_rdata <= {23'h0, global_ie_r, 1'b0, chan_r, 3'h0,
                          conv_enable_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ACC_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : acc_ctrl

// ===== pkg/acc_pkg.sv
// Package for the comparator control block: offsets, fields, resets, modes.
// Assumes a 32-bit AXI4-Lite register bus with one register per word.
package acc_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACC_OFF_CTRL_STAT = 8'h50;
  localparam logic [7:0] ACC_OFF_CONV_B    = 8'h7b;
  localparam logic [7:0] ACC_OFF_PIN_DIS   = 8'h7f;
  localparam logic [7:0] ACC_OFF_HOOKS     = 8'h84; // Converter/cpu hooks

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ACC_B_POWER_OFF   = 7;
  localparam int ACC_B_BANDGAP     = 6;
  localparam int ACC_B_OUT_SYNC    = 5;
  localparam int ACC_B_IRQ_FLAG    = 4;
  localparam int ACC_B_IRQ_ENABLE  = 3;
  localparam int ACC_B_CAPTURE     = 2;
  localparam int ACC_B_MODE_HI     = 1;
  localparam int ACC_B_MODE_LO     = 0;
  localparam int ACC_B_MUX_ENABLE  = 6;
  localparam int ACC_B_NEG_OFF     = 1;
  localparam int ACC_B_POS_OFF     = 0;
  // Hooks register: converter enable, channel select, global enable
  localparam int ACC_B_CONV_EN     = 0;
  localparam int ACC_B_CHAN_LO     = 4;
  localparam int ACC_B_GLOBAL_IE   = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACC_RST_CTRL  = 8'h00;
  localparam logic [7:0] ACC_RST_CONVB = 8'h00;
  localparam logic [7:0] ACC_RST_PIN   = 8'h00;
  localparam logic [2:0] ACC_RST_CHAN  = 3'h0;

  // Converter-control-B bits that software may write
  localparam logic [7:0] ACC_CONVB_WMASK = 8'h47;
  localparam logic [7:0] ACC_PIN_WMASK   = 8'h03;

  // Flag-setting event modes
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE   = 2'h0,
    ACC_MODE_RESERVED = 2'h1,
    ACC_MODE_FALL     = 2'h2,
    ACC_MODE_RISE     = 2'h3
  } acc_mode_t;

  // Negative-input source select (to the analog core)
  localparam logic [3:0] ACC_NEG_PIN = 4'h8; // Index 0..7 = converter pins

  localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

endpackage : acc_pkg

// ===== core/acc_sync.sv
// Two-stage synchroniser for one level into the aclk domain.
// Assumes the input is asynchronous; first stage feeds only the second.
`timescale 1ns/1ps
module acc_sync
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic meta_r;

  // Second stage is the only reader of the first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : acc_sync

// ===== tb/acc_cmp_model.sv
// Behavioural comparator core: input routing, power and decision.
// Assumes the bench sets all voltages, in millivolts, as plain levels.
`timescale 1ns/1ps
module acc_cmp_model
  import acc_pkg::*;
(
  // Control from the block
  input  wire logic        power_off,
  input  wire logic        bandgap_sel,
  input  wire logic [3:0]  neg_sel,
  // Analog levels from the bench
  input  wire logic [15:0] v_pos,
  input  wire logic [15:0] v_bg,
  input  wire logic [15:0] v_neg,
  input  wire logic [15:0] v_chan [8],
  // Raw decision
  output logic             raw
);
  logic [15:0] v_p;
  logic [15:0] v_n;

  // ----------------------------------------------------------------------
  // Input selection
  // ----------------------------------------------------------------------
  always_comb
  begin
    v_p = bandgap_sel ? v_bg : v_pos;
    v_n = (neg_sel == ACC_NEG_PIN) ? v_neg
                                   : v_chan[neg_sel[2:0]];
  end

  // Delay mimics analog settling, so edges land off the clock
  assign #3 raw = !power_off && (v_p > v_n);
endmodule : acc_cmp_model

// ===== tb/acc_ctrl_properties.sv
// Port checker for the comparator control block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module acc_ctrl_properties
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus responses
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Comparator side
  input wire logic        cmp_raw_out,
  input wire logic [3:0]  cmp_neg_select,
  input wire logic        neg_pin_input_off,
  input wire logic        pos_pin_input_off,
  input wire logic        pos_pin_digital,
  input wire logic        neg_pin_port_bit,
  input wire logic        pos_pin_port_bit,
  input wire logic        cpu_vector_ack,
  input wire logic        cmp_irq_req,
  input wire logic        cmp_capture_route,
  input wire logic        timer_capture_in
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_NEG_GATE: assert property (
    neg_pin_input_off |-> !neg_pin_port_bit)
    else $error("neg port bit not gated");
  AST_POS_PASS: assert property (
    !pos_pin_input_off |-> pos_pin_port_bit == pos_pin_digital)
    else $error("pos port bit not passed");
  AST_SEL_LEGAL: assert property (cmp_neg_select <= ACC_NEG_PIN)
    else $error("neg select out of range");
  AST_CAP_OFF: assert property (
    !cmp_capture_route [*2] |-> !timer_capture_in)
    else $error("capture fed while unrouted");
  AST_CAP_FOLLOW: assert property (
    (cmp_capture_route && $stable(cmp_raw_out)) [*5]
    |-> timer_capture_in == cmp_raw_out)
    else $error("capture not following output");
  AST_VEC_CLR: assert property (
    $stable(cmp_raw_out) [*4] ##0 cpu_vector_ack |=> !cmp_irq_req)
    else $error("request stays after vectoring");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");

  // Main scenarios reached
  cover property (cmp_irq_req);
  cover property ($rose(timer_capture_in));
  cover property (s_axi_rvalid && s_axi_rresp == ACC_RESP_SLVERR);
endmodule : acc_ctrl_properties

bind acc_ctrl acc_ctrl_properties u_props (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .cmp_raw_out, .cmp_neg_select,
  .neg_pin_input_off, .pos_pin_input_off, .pos_pin_digital, .neg_pin_port_bit,
  .pos_pin_port_bit, .cpu_vector_ack, .cmp_irq_req, .cmp_capture_route,
  .timer_capture_in);

// ===== tb/testbench.sv
// Self-checking bench for the comparator control block.
// Assumes acc_ctrl, the comparator model and the bound checker.
`timescale 1ns/1ps
module testbench
  import acc_pkg::*;
;
  typedef struct { logic [31:0] d; logic [31:0] m; logic [1:0] r; } acc_exp_t;
  localparam int IDX_CTRL = 'h50;
  localparam int IDX_CONVB = 'h7b;
  localparam int IDX_PIN = 'h7f;
  localparam logic [9:0] A_CTRL = 10'(IDX_CTRL * 4);
  localparam logic [9:0] A_CONVB = 10'(IDX_CONVB * 4);
  localparam logic [9:0] A_PIN = 10'(IDX_PIN * 4);
  localparam logic [9:0] A_HOOKS = {ACC_OFF_HOOKS, 2'b00};
  localparam logic [1:0] OK = ACC_RESP_OKAY;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0, cmp_neg_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmp_raw_out, cmp_power_off, cmp_bandgap_select;
  logic neg_pin_digital = 0, pos_pin_digital = 0, cpu_vector_ack = 0;
  logic neg_pin_input_off, pos_pin_input_off, neg_pin_port_bit;
  logic pos_pin_port_bit, cmp_irq_req, cmp_capture_route, timer_capture_in;
  logic [15:0] v_pos = 0, v_bg = 16'd1100, v_neg = 16'd1000, v_chan [8];
  logic me, ce, sr, sf;
  logic [2:0] tr;
  logic [3:0] es;
  acc_mode_t m;
  acc_mode_t modes [4] = '{ACC_MODE_TOGGLE, ACC_MODE_RESERVED,
                           ACC_MODE_FALL, ACC_MODE_RISE};
  acc_exp_t exp_q [$];
  int n_mismatch = 0;
  int checks = 0;

  acc_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmp_raw_out, .cmp_power_off, .cmp_bandgap_select, .cmp_neg_select,
    .neg_pin_digital, .pos_pin_digital, .neg_pin_input_off, .pos_pin_input_off,
    .neg_pin_port_bit, .pos_pin_port_bit, .cpu_vector_ack, .cmp_irq_req,
    .cmp_capture_route, .timer_capture_in);
  acc_cmp_model u_model (.power_off(cmp_power_off), .v_pos, .v_bg, .v_neg,
    .bandgap_sel(cmp_bandgap_select), .neg_sel(cmp_neg_select), .v_chan,
    .raw(cmp_raw_out));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string w, input logic [31:0] e, g, k);
    checks++;
    if ((g & k) !== (e & k))
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", w, e & k, g & k);
    end
  endtask : chk

  // Both halves offered together; each dropped once taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back('{d: 32'h0, m: 32'h0, r: r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] d, k,
                    input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back('{d: d, m: k, r: r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (!s_axi_rvalid);
  endtask : rd

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Clock, watchdog and response monitor
  always #4 aclk = ~aclk;
  initial
  begin
    repeat (6000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end
  always @(posedge aclk)
  begin
    acc_exp_t e;
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      e = exp_q.pop_front();
      if (s_axi_bvalid)
        chk("bresp", 32'(e.r), 32'(s_axi_bresp), 32'h3);
      else
      begin
        chk("rresp", 32'(e.r), 32'(s_axi_rresp), 32'h3);
        chk("rdata", e.d, s_axi_rdata, e.m);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    foreach (v_chan[i]) v_chan[i] = 16'd3000;
    void'($urandom(32'hc52f));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTRL, 32'h0, 32'hffffffdf, OK);
    rd(A_CONVB, 32'h0, '1, OK);
    rd(A_PIN, 32'h0, '1, OK);
    chk("neg_sel", 32'(ACC_NEG_PIN), 32'(cmp_neg_select), 32'hf);
    rd(8'h20, 32'h0, '1, ACC_RESP_SLVERR);
    wr(8'h20, 32'hff, ACC_RESP_SLVERR);
    $display("test reset and unmapped done");
    wr(A_CTRL, 32'hc4, OK);
    chk("power", 1, 32'(cmp_power_off), 1);
    chk("bandgap", 1, 32'(cmp_bandgap_select), 1);
    chk("route", 1, 32'(cmp_capture_route), 1);
    rd(A_CTRL, 32'hc4, 32'hffffffdf, OK);
    wr(A_CTRL, 32'h0, OK);
    chk("power", 0, 32'(cmp_power_off), 1);
    $display("test control bits done");
    for (int i = 0; i < 16; i++)
    begin
      me = (i < 8) ? 1'b1 : 1'($urandom);
      ce = (i < 8) ? 1'b0 : 1'($urandom);
      tr = 3'($urandom);
      wr(A_CONVB, {24'h0, 1'b0, me, 3'h0, tr}, OK);
      wr(A_HOOKS, {25'h0, 3'(i), 3'h0, ce}, OK);
      es = (me && !ce) ? 4'(i % 8) : ACC_NEG_PIN;
      // Select is registered one edge after the hooks register
      @(posedge aclk);
      chk("neg_sel", 32'(es), 32'(cmp_neg_select), 32'hf);
      rd(A_CONVB, {24'h0, 1'b0, me, 3'h0, tr}, '1, OK);
    end
    $display("test negative input select done");
    neg_pin_digital <= 1'b1;
    pos_pin_digital <= 1'b1;
    wr(A_PIN, 32'hff, OK);
    rd(A_PIN, 32'h03, '1, OK);
    chk("ports", 0, {neg_pin_port_bit, pos_pin_port_bit}, 3);
    chk("offs", 3, {neg_pin_input_off, pos_pin_input_off}, 3);
    wr(A_PIN, 32'h0, OK);
    chk("ports", 3, {neg_pin_port_bit, pos_pin_port_bit}, 3);
    $display("test pin input disable done");
    wr(A_CONVB, 32'h0, OK);
    wr(A_HOOKS, 32'h100, OK);
    foreach (modes[k])
    begin
      m = modes[k];
      sr = (m == ACC_MODE_TOGGLE) || (m == ACC_MODE_RISE);
      sf = (m == ACC_MODE_TOGGLE) || (m == ACC_MODE_FALL);
      wr(A_CTRL, 32'h04 | 32'(m), OK);
      wr(A_CTRL, 32'h14 | 32'(m), OK);
      v_pos <= 16'd2000;
      repeat (6) @(posedge aclk);
      chk("capture", 1, 32'(timer_capture_in), 1);
      rd(A_CTRL, 32'h24 | 32'(m) | {sr, 4'h0}, '1, OK);
      wr(A_CTRL, 32'h14 | 32'(m), OK);
      rd(A_CTRL, 32'h24 | 32'(m), '1, OK);
      v_pos <= 16'd500;
      repeat (6) @(posedge aclk);
      wr(A_CTRL, 32'h0c | 32'(m), OK);
      chk("irq", 32'(sf), 32'(cmp_irq_req), 1);
      rd(A_CTRL, 32'h0c | 32'(m) | {sf, 4'h0}, '1, OK);
      cpu_vector_ack <= 1'b1;
      @(posedge aclk);
      cpu_vector_ack <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("irq", 0, 32'(cmp_irq_req), 1);
      wr(A_CTRL, 32'h04 | 32'(m), OK);
    end
    $display("test flag modes done");
    @(posedge aclk);
    end_of_test();
  end
endmodule : testbench
